// [bench/sfe_master.sv]
// SPI master model that frames opcodes, addresses and data towards the front end.
`timescale 1ns/1ps

module sfe_master (
    input  wire logic clk_sys,
    input  wire logic spiDataOut,
    output logic      spiSelN,
    output logic      spiClk,
    output logic      spiDataIn
);
    // ------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------
    // Four system cycles per half period make a 64 ns clock, well under 20 MHz.
    task automatic half();
        repeat (4) @(negedge clk_sys);
    endtask

    initial begin
        spiSelN   = 1'b1;
        spiClk    = 1'b0;
        spiDataIn = 1'b0;
    end

    // ------------------------------------------------------------
    // Frames
    // ------------------------------------------------------------
    // One select period carries exactly one opcode; the model makes every clock edge.
    task automatic frame(input logic cpol, input int n, input logic [31:0] tx,
                         output logic [31:0] rx);
        rx = 32'h0;
        spiClk = cpol;
        half();
        spiSelN = 1'b0;
        half();
        for (int i = 0; i < 8 * n; i++) begin
            spiClk    = 1'b0;
            spiDataIn = tx[31 - i];
            half();
            spiClk = 1'b1;
            half();
            rx[31 - i] = spiDataOut;
        end
        spiClk = cpol;
        half();
        spiSelN = 1'b1;
        // The released data line must not keep showing the last bit.
        spiDataIn = ~spiDataIn;
        half();
    endtask
endmodule // sfe_master

// [bench/testbench.sv]
// Self-checking bench for the SPI command front end.
`timescale 1ns/1ps

module testbench;
    logic        clk_sys, reset, spiSelN, spiClk, spiDataIn, spiDataOut, spiDataOutOeN;
    logic        memWrite, memRead, writeEnableLatch, oeSeen, misoLine;
    logic [8:0]  memAddr, wrAddr;
    logic [7:0]  memWrData, memRdData, wrData;
    logic [1:0]  blockProtect;
    logic [31:0] rx;
    int          err_total, check_count, wrCount, rdCount, cycles;

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    sfe_spi_frontend u_sfe_spi_frontend (
        .clk_sys(clk_sys), .reset(reset), .spiSelN(spiSelN), .spiClk(spiClk),
        .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutOeN(spiDataOutOeN),
        .memAddr(memAddr), .memWrite(memWrite), .memWrData(memWrData), .memRead(memRead),
        .memRdData(memRdData), .writeEnableLatch(writeEnableLatch),
        .blockProtect(blockProtect));

    sfe_master u_sfe_master (.clk_sys(clk_sys), .spiDataOut(misoLine), .spiSelN(spiSelN),
        .spiClk(spiClk), .spiDataIn(spiDataIn));

    // A released output line floats to its pull-up, so a late enable reads as ones.
    assign misoLine = spiDataOutOeN ? 1'b1 : spiDataOut;

    // ------------------------------------------------------------
    // Memory model and monitors
    // ------------------------------------------------------------
    function automatic logic [7:0] memFn(input logic [8:0] a);
        return a[7:0] ^ {a[8], 7'h5a};
    endfunction

    always @(negedge clk_sys) memRdData <= memFn(memAddr);

    // Pulses are looked at mid-cycle, where they and their address have settled.
    always @(negedge clk_sys) begin
        if (memWrite === 1'b1) begin
            wrCount++;
            wrAddr = memAddr;
            wrData = memWrData;
        end
        if (memRead === 1'b1) rdCount++;
        if (spiDataOutOeN === 1'b0) oeSeen = 1'b1;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic run(input logic cpol, input int n, input logic [31:0] tx);
        oeSeen = 1'b0;
        u_sfe_master.frame(cpol, n, tx, rx);
        repeat (4) @(negedge clk_sys);
        check(spiDataOutOeN, 1'b1);
    endtask

    task stop_test;
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check({writeEnableLatch, blockProtect, memAddr}, 12'h000);
        $display("test reset done");
    endtask

    task automatic t_status_read;
        for (int m = 0; m < 2; m++) begin
            run(m[0], 2, 32'h0500_0000);
            check({oeSeen, rx[23:16]}, 9'h100);
        end
        $display("test status_read done");
    endtask

    task automatic t_latch;
        run(1'b1, 2, 32'h06a5_0000);
        check({oeSeen, writeEnableLatch}, 2'b01);
        run(1'b0, 2, 32'h0500_0000);
        check(rx[23:16], 8'h02);
        run(1'b1, 2, 32'h0401_0000);
        check(writeEnableLatch, 1'b0);
        run(1'b0, 2, 32'h0500_0000);
        check(rx[23:16], 8'h00);
        $display("test latch done");
    endtask

    task automatic t_status_write;
        run(1'b0, 2, 32'h010c_0000);
        check(blockProtect, 2'h0);
        run(1'b0, 1, 32'h0600_0000);
        run(1'b0, 2, 32'h01ff_0000);
        check({blockProtect, writeEnableLatch}, 3'b110);
        run(1'b0, 2, 32'h0500_0000);
        check(rx[23:16], 8'h0c);
        run(1'b0, 1, 32'h0600_0000);
        run(1'b0, 2, 32'h0100_0000);
        check(blockProtect, 2'h0);
        $display("test status_write done");
    endtask

    task automatic t_mem_write;
        run(1'b0, 1, 32'h0600_0000);
        wrCount = 0;
        run(1'b1, 4, 32'h0afe_a1b2);
        check({wrCount[3:0], wrAddr, wrData}, {4'h2, 9'h1ff, 8'hb2});
        check({memAddr, writeEnableLatch}, 10'h000);
        run(1'b0, 3, 32'h0210_3300);
        check(wrCount[3:0], 4'h2);
        $display("test mem_write done");
    endtask

    task automatic t_mem_read;
        rdCount = 0;
        run(1'b0, 4, 32'h0b05_0000);
        check(rx[15:0], {memFn(9'h105), memFn(9'h106)});
        check({rdCount[3:0], memAddr}, {4'h3, 9'h108});
        $display("test mem_read done");
    endtask

    task automatic t_bad_opcode;
        run(1'b0, 3, 32'hff06_0500);
        check({oeSeen, writeEnableLatch}, 2'b00);
        $display("test bad_opcode done");
    endtask

    initial begin
        reset       = 1'b1;
        memRdData   = 8'h00;
        err_total   = 0;
        check_count = 0;
        wrCount     = 0;
        cycles      = 0;
        oeSeen      = 1'b0;
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        repeat (8) @(negedge clk_sys);
        t_reset();
        t_status_read();
        t_latch();
        t_status_write();
        t_mem_write();
        t_mem_read();
        t_bad_opcode();
        stop_test();
    end
endmodule // testbench

// [src/sfe_consts.svh]
// Opcode values, status bit positions and reset values for the SPI command front end.
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH

`define SFE_OP_LATCH_SET    8'h06
`define SFE_OP_LATCH_CLEAR  8'h04
`define SFE_OP_STATUS_READ  8'h05
`define SFE_OP_STATUS_WRITE 8'h01
`define SFE_OP_MEM_READ_LO  3'h3
`define SFE_OP_MEM_WRITE_LO 3'h2
`define SFE_OP_ADDR_BIT     3
`define SFE_ST_WEL_BIT      1
`define SFE_ST_BP_LO        2
`define SFE_ST_BP_HI        3
`define SFE_BP_RESET        2'h0
`define SFE_ADDR_RESET      9'h000

`endif

// [src/sfe_pkg.sv]
// Types shared by the SPI command front end.
package sfe_pkg;
    typedef enum logic [2:0] {
        SFE_IDLE,
        SFE_OPCODE,
        SFE_ADDR,
        SFE_WRDATA,
        SFE_RDDATA,
        SFE_STWR,
        SFE_STRD,
        SFE_IGNORE
    } sfe_state_t;
endpackage

// [src/sfe_spi_frontend.sv]
// SPI slave command front end with write enable latch and status register.
// Notes on behaviour
// - Sample input on rising, drive output on falling.
// - Clock level at select picks mode 0/3.
// - Mode 3 ignores the initial falling edge.
// - First eight bits are the opcode.
// - Deselected: ignore input, output tristated.
// - All bytes travel most significant bit first.
// - Nine-bit address: opcode bit plus next byte.
// - Decode latch set, clear, status read.
// - Decode status write, memory read, memory write.
// - Opcode bit 3 is address bit 8.
// - Bad opcode: ignore until next select.
// - Latch clear after reset.
// - Latch set command sets the latch.
// - Status write cannot change the latch.
// - Select rise clears latch after writes.
// - Latch clear command clears, reads zero.
// - Eight-bit status register.
// - Latch at bit 1, spare bits zero.
// - Status read shifts out status byte.
// - Device is slave only.
`timescale 1ns/1ps
`include "sfe_consts.svh"

module sfe_spi_frontend
    import sfe_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       spiSelN,
    input  wire logic       spiClk,
    input  wire logic       spiDataIn,
    output logic            spiDataOut,
    output logic            spiDataOutOeN,
    output logic [8:0]      memAddr,
    output logic            memWrite,
    output logic [7:0]      memWrData,
    output logic            memRead,
    input  wire logic [7:0] memRdData,
    output logic            writeEnableLatch,
    output logic [1:0]      blockProtect
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sckSync_ff;
    logic [2:0] selSync_ff;
    logic [1:0] siSync_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sckSync_ff <= 3'h0;
            selSync_ff <= 3'h7;
            siSync_ff  <= 2'h0;
        end else begin
            sckSync_ff <= {sckSync_ff[1:0], spiClk};
            selSync_ff <= {selSync_ff[1:0], spiSelN};
            siSync_ff  <= {siSync_ff[0], spiDataIn};
        end
    end

    logic sckRise;
    logic sckFall;
    logic selFall;
    logic selRise;
    logic selected;
    logic siBit;

    assign sckRise  = sckSync_ff[1] & ~sckSync_ff[2];
    assign sckFall  = ~sckSync_ff[1] & sckSync_ff[2];
    assign selFall  = ~selSync_ff[1] & selSync_ff[2];
    assign selRise  = selSync_ff[1] & ~selSync_ff[2];
    assign selected = ~selSync_ff[1];
    assign siBit    = siSync_ff[1];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic isMemOp(input logic [7:0] op, input logic [2:0] lo);
        isMemOp = (op[7:4] == 4'h0) && (op[2:0] == lo);
    endfunction

    function automatic logic isTxState(input sfe_state_t st);
        isTxState = (st == SFE_STRD) || (st == SFE_RDDATA);
    endfunction

    // ------------------------------------------------------------
    // Command state
    // ------------------------------------------------------------
    sfe_state_t state_ff, nxt_state;
    logic [2:0] bitCnt_ff, nxt_bitCnt;
    logic [7:0] rx_ff, nxt_rx;
    logic [7:0] tx_ff, nxt_tx;
    logic       so_ff, nxt_so;
    logic       soOeN_ff, nxt_soOeN;
    logic       mode3_ff, nxt_mode3;
    logic       rdOp_ff, nxt_rdOp;
    logic       pendClr_ff, nxt_pendClr;
    logic       wel_ff, nxt_wel;
    logic [1:0] bp_ff, nxt_bp;
    logic [8:0] addr_ff, nxt_addr;
    logic       memWr_ff, nxt_memWr;
    logic [7:0] wrData_ff, nxt_wrData;
    logic       memRd_ff, nxt_memRd;
    logic       loadTx_ff, nxt_loadTx;
    logic [7:0] status;
    logic [7:0] rxByte;
    logic       byteDone;

    always_comb begin
        status = 8'h00;
        status[`SFE_ST_WEL_BIT] = wel_ff;
        status[`SFE_ST_BP_HI:`SFE_ST_BP_LO] = bp_ff;
    end

    assign rxByte   = {rx_ff[6:0], siBit};
    assign byteDone = selected && !selFall && sckRise && (bitCnt_ff == 3'h7)
                      && (state_ff != SFE_IDLE) && (state_ff != SFE_IGNORE);

    always_comb begin
        nxt_state   = state_ff;
        nxt_bitCnt  = bitCnt_ff;
        nxt_rx      = rx_ff;
        nxt_tx      = tx_ff;
        nxt_so      = so_ff;
        nxt_mode3   = mode3_ff;
        nxt_rdOp    = rdOp_ff;
        nxt_pendClr = pendClr_ff;
        nxt_wel     = wel_ff;
        nxt_bp      = bp_ff;
        nxt_addr    = addr_ff;
        nxt_memWr   = 1'b0;
        nxt_wrData  = wrData_ff;
        nxt_memRd   = 1'b0;
        nxt_loadTx  = memRd_ff;
        // Address moves on only after the strobe so the strobe sees the old address.
        if (memWr_ff || loadTx_ff) begin
            nxt_addr = 9'(addr_ff + 9'h001);
        end
        if (loadTx_ff) begin
            nxt_tx = memRdData;
        end
        if (selFall) begin
            nxt_state   = SFE_OPCODE;
            nxt_bitCnt  = 3'h0;
            nxt_mode3   = sckSync_ff[1];
            nxt_pendClr = 1'b0;
        end else if (!selected) begin
            nxt_state = SFE_IDLE;
            if (selRise && pendClr_ff) begin
                nxt_wel = 1'b0;
            end
        end else begin
            // Only rising edges count bits, so the stray fall in mode 3 is harmless.
            if (sckRise && state_ff != SFE_IDLE && state_ff != SFE_IGNORE) begin
                nxt_rx     = rxByte;
                nxt_bitCnt = 3'(bitCnt_ff + 3'h1);
            end
            if (byteDone) begin
                case (state_ff)
                    SFE_OPCODE: begin
                        if (rxByte == `SFE_OP_LATCH_SET) begin
                            nxt_wel   = 1'b1;
                            nxt_state = SFE_IGNORE;
                        end else if (rxByte == `SFE_OP_LATCH_CLEAR) begin
                            nxt_pendClr = 1'b1;
                            nxt_state   = SFE_IGNORE;
                        end else if (rxByte == `SFE_OP_STATUS_READ) begin
                            nxt_tx    = status;
                            nxt_state = SFE_STRD;
                        end else if (rxByte == `SFE_OP_STATUS_WRITE) begin
                            nxt_pendClr = 1'b1;
                            nxt_state   = SFE_STWR;
                        end else if (isMemOp(rxByte, `SFE_OP_MEM_READ_LO)) begin
                            nxt_addr[8] = rxByte[`SFE_OP_ADDR_BIT];
                            nxt_rdOp    = 1'b1;
                            nxt_state   = SFE_ADDR;
                        end else if (isMemOp(rxByte, `SFE_OP_MEM_WRITE_LO)) begin
                            nxt_addr[8] = rxByte[`SFE_OP_ADDR_BIT];
                            nxt_rdOp    = 1'b0;
                            nxt_pendClr = 1'b1;
                            nxt_state   = SFE_ADDR;
                        end else begin
                            nxt_state = SFE_IGNORE;
                        end
                    end
                    SFE_ADDR: begin
                        nxt_addr[7:0] = rxByte;
                        if (rdOp_ff) begin
                            nxt_memRd = 1'b1;
                            nxt_state = SFE_RDDATA;
                        end else begin
                            nxt_state = SFE_WRDATA;
                        end
                    end
                    SFE_WRDATA: begin
                        if (wel_ff) begin
                            nxt_memWr  = 1'b1;
                            nxt_wrData = rxByte;
                        end
                    end
                    SFE_RDDATA: begin
                        nxt_memRd = 1'b1;
                    end
                    SFE_STWR: begin
                        // The latch bit of the written byte is dropped on purpose.
                        if (wel_ff) begin
                            nxt_bp = rxByte[`SFE_ST_BP_HI:`SFE_ST_BP_LO];
                        end
                        nxt_state = SFE_IGNORE;
                    end
                    SFE_STRD: begin
                        nxt_tx = status;
                    end
                    default: begin
                        nxt_state = SFE_IGNORE;
                    end
                endcase
            end else if (sckFall && isTxState(state_ff)) begin
                nxt_so = tx_ff[7];
                nxt_tx = {tx_ff[6:0], 1'b0};
            end
        end
        nxt_soOeN = ~(selected && !selFall && isTxState(nxt_state));
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff   <= SFE_IDLE;
            bitCnt_ff  <= 3'h0;
            rx_ff      <= 8'h00;
            tx_ff      <= 8'h00;
            so_ff      <= 1'b0;
            soOeN_ff   <= 1'b1;
            mode3_ff   <= 1'b0;
            rdOp_ff    <= 1'b0;
            pendClr_ff <= 1'b0;
            wel_ff     <= 1'b0;
            bp_ff      <= `SFE_BP_RESET;
            addr_ff    <= `SFE_ADDR_RESET;
            memWr_ff   <= 1'b0;
            wrData_ff  <= 8'h00;
            memRd_ff   <= 1'b0;
            loadTx_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            bitCnt_ff  <= nxt_bitCnt;
            rx_ff      <= nxt_rx;
            tx_ff      <= nxt_tx;
            so_ff      <= nxt_so;
            soOeN_ff   <= nxt_soOeN;
            mode3_ff   <= nxt_mode3;
            rdOp_ff    <= nxt_rdOp;
            pendClr_ff <= nxt_pendClr;
            wel_ff     <= nxt_wel;
            bp_ff      <= nxt_bp;
            addr_ff    <= nxt_addr;
            memWr_ff   <= nxt_memWr;
            wrData_ff  <= nxt_wrData;
            memRd_ff   <= nxt_memRd;
            loadTx_ff  <= nxt_loadTx;
        end
    end

    assign spiDataOut       = so_ff;
    assign spiDataOutOeN    = soOeN_ff;
    assign memAddr          = addr_ff;
    assign memWrite         = memWr_ff;
    assign memWrData        = wrData_ff;
    assign memRead          = memRd_ff;
    assign writeEnableLatch = wel_ff;
    assign blockProtect     = bp_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_idle_tristate: assert property (@(posedge clk_sys) disable iff (reset)
        selSync_ff[1] |=> soOeN_ff)
        else $error("Output driven while deselected.");

    chk_wel_powerup: assert property (@(posedge clk_sys)
        reset |=> !wel_ff)
        else $error("Latch not clear after reset.");

    chk_wel_set: assert property (@(posedge clk_sys) disable iff (reset)
        (byteDone && state_ff == SFE_OPCODE && rxByte == 8'h06) |=> wel_ff ##1 wel_ff)
        else $error("Latch set command did not set the latch.");

    chk_wel_autoclr: assert property (@(posedge clk_sys) disable iff (reset)
        (selRise && pendClr_ff) |=> !wel_ff)
        else $error("Latch survived end of write transaction.");

    chk_mode_capture: assert property (@(posedge clk_sys) disable iff (reset)
        selFall |=> (mode3_ff == $past(sckSync_ff[1])) && state_ff == SFE_OPCODE)
        else $error("Clock mode not captured at select.");

    chk_so_on_fall: assert property (@(posedge clk_sys) disable iff (reset)
        (so_ff != $past(so_ff)) |-> $past(sckFall))
        else $error("Output changed away from a falling clock edge.");

    chk_bad_opcode: assert property (@(posedge clk_sys) disable iff (reset)
        (byteDone && state_ff == SFE_OPCODE && rxByte[7:4] != 4'h0)
        |=> (state_ff == SFE_IGNORE && soOeN_ff) [*2])
        else $error("Bad opcode was not ignored.");

    chk_addr_hi: assert property (@(posedge clk_sys) disable iff (reset)
        (byteDone && state_ff == SFE_OPCODE && isMemOp(rxByte, 3'h3))
        |=> memAddr[8] == $past(rxByte[3]))
        else $error("Address bit 8 not taken from opcode.");

    chk_stwr_wel: assert property (@(posedge clk_sys) disable iff (reset)
        (byteDone && state_ff == SFE_STWR) |=> wel_ff == $past(wel_ff))
        else $error("Status write altered the latch.");

    chk_status_load: assert property (@(posedge clk_sys) disable iff (reset)
        (byteDone && state_ff == SFE_OPCODE && rxByte == 8'h05)
        |=> tx_ff == {4'h0, $past(bp_ff), $past(wel_ff), 1'b0})
        else $error("Status byte not loaded for shifting out.");

endmodule // sfe_spi_frontend
